// [core/paged_serial_pkg.sv]
/*
  Constants and types for the paged serial register port.
  Assumes one 100 MHz system clock and a host-driven serial clock sampled by it.
*/
`default_nettype none

package paged_serial_pkg;

  localparam int          ADDR_W        = 5;       // Register address width within a page
  localparam int          NUM_PAGES     = 3;       // Number of register pages
  localparam int          REGS_PER_PAGE = 32;      // Registers per page, last one is the page register
  localparam logic [4:0]  PAGE_REG_ADDR = 5'h1F;   // Page register position in every page
  localparam logic [7:0]  PAGE_CODE_0   = 8'h00;   // First page number
  localparam logic [7:0]  PAGE_CODE_1   = 8'h01;   // Second page number
  localparam logic [7:0]  PAGE_CODE_TEN = 8'h0A;   // Third page number
  localparam logic [1:0]  PAGE_IDX_0    = 2'h0;    // Storage index of the first page
  localparam logic [1:0]  PAGE_IDX_1    = 2'h1;    // Storage index of the second page
  localparam logic [1:0]  PAGE_IDX_TEN  = 2'h2;    // Storage index of the third page
  localparam logic [7:0]  REG_RESET     = 8'h00;   // Reset value of every stored register
  localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;    // Bit counter value of a byte's last bit
  localparam logic [2:0]  ONE_BYTE      = 3'h1;    // Last data byte of a burst
  localparam logic        RW_WRITE      = 1'b0;    // Read/write flag value for a write
  localparam logic        RW_READ       = 1'b1;    // Read/write flag value for a read

  // Instruction byte, most significant bit first on the wire
  typedef struct packed {
    logic       rw;          // 0 write, 1 read
    logic [1:0] byte_count;  // byte_count_hi, byte_count_lo: data bytes minus one
    logic [4:0] addr;        // First register of the burst
  } instr_t;

  // Serial pins as seen through the synchroniser
  typedef struct packed {
    logic sclk;              // Host serial clock
    logic select_n;          // Frame select, active low
    logic sdio;              // Serial data in
  } pins_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA,
    ST_DONE
  } port_state_t;

endpackage

`default_nettype wire

// [core/paged_serial_register_port.sv]
/*
  Serial register port with three pages of 32 registers, 3-wire or 4-wire.
  Assumes the host owns the serial clock and select; the serial pins are sampled
  by clk_in through two flip-flops, so the serial clock must stay well below
  a quarter of clk_in.
*/
// What this block does
// - 3-wire: shared pin carries both directions
// - 4-wire: shared pin input, separate output pin
// - One select frame holds 2 to 5 bytes
// - Flag 0 writes, flag 1 reads
// - Count codes 00..11 mean 1..4 data bytes
// - Five address bits name first register
// - Further bytes go to lower addresses
// - Three pages of 32 registers each
// - Last register holds page, writes of page 00, 01 or 0A switch it
// - Arrangement comes from the four_wire_in pin, there is no mode register
`default_nettype none

module paged_serial_register_port
  import paged_serial_pkg::*;
(
  input  wire logic       clk_in,                // System clock, 100 MHz
  input  wire logic       resetn_in,             // Synchronous reset, active low
  input  wire logic       sclk_in,               // Host serial clock pin
  input  wire logic       serial_select_n_in,    // Frame select pin, active low
  input  wire logic       sdio_in,               // Shared data pin, input side
  input  wire logic       four_wire_in,          // 1 selects the 4-wire arrangement
  input  wire logic [1:0] cfg_page_in,           // Local read port page index
  input  wire logic [4:0] cfg_addr_in,           // Local read port address
  output logic            sdio_out,              // Shared data pin, output side
  output logic            sdio_oe_n_out,         // Shared pin enable, low drives
  output logic            serial_data_out,       // Separate read data pin
  output logic            serial_data_oe_n_out,  // Separate pin enable, low drives
  output logic [7:0]      page_out,              // Active page number
  output logic [7:0]      cfg_data_out,          // Local read port data
  output logic            wr_strobe_out          // Pulse when a register is written
);

  // Synchroniser stages; stage one is read only by stage two
  pins_t s1_r, s2_r, s3_r;
  pins_t s1_nxt, s2_nxt, s3_nxt;

  // Port state
  port_state_t state_r, state_nxt;              // Frame sequencer
  instr_t      instr_r, instr_nxt;              // Captured instruction
  logic [2:0]  bit_cnt_r, bit_cnt_nxt;          // Bit within current byte
  logic [2:0]  bytes_left_r, bytes_left_nxt;    // Data bytes still to go
  logic [4:0]  addr_r, addr_nxt;                // Register of current byte
  logic [7:0]  shift_in_r, shift_in_nxt;        // Incoming bits
  logic [7:0]  shift_out_r, shift_out_nxt;      // Outgoing read byte
  logic        out_bit_r, out_bit_nxt;          // Bit on the wire
  logic        drive_r, drive_nxt;              // Read data is being driven
  logic        wr_r, wr_nxt;                    // Write strobe
  logic [7:0]  page_r, page_nxt;                // Active page number
  logic [7:0]  cfg_r, cfg_nxt;                  // Local read data
  logic [7:0]  regs_r   [NUM_PAGES][REGS_PER_PAGE-1];  // Stored registers
  logic [7:0]  regs_nxt [NUM_PAGES][REGS_PER_PAGE-1];

  logic        sclk_rise;                       // Serial clock rising edge
  logic        sclk_fall;                       // Serial clock falling edge
  logic [7:0]  byte_in;                         // Byte completed on this edge

  // Page number to storage index
  function automatic logic [1:0] page_idx(input logic [7:0] code);
    logic [1:0] idx;
    idx = PAGE_IDX_0;
    if (code == PAGE_CODE_1)
      idx = PAGE_IDX_1;
    else if (code == PAGE_CODE_TEN)
      idx = PAGE_IDX_TEN;
    return idx;
  endfunction

  // Register read in a page; the page register reads the same in every page
  function automatic logic [7:0] read_reg(input logic [1:0] idx, input logic [4:0] a);
    logic [7:0] v;
    v = REG_RESET;
    if (a == PAGE_REG_ADDR)
      v = page_r;
    else if (idx < 2'(NUM_PAGES))
      v = regs_r[idx][a];
    return v;
  endfunction

  // Pin synchroniser, next values
  always_comb
  begin
    s1_nxt = '{sclk: sclk_in, select_n: serial_select_n_in, sdio: sdio_in};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // Pin synchroniser; idle values keep the frame closed out of reset
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s1_r <= '{sclk: 1'b0, select_n: 1'b1, sdio: 1'b0};
      s2_r <= '{sclk: 1'b0, select_n: 1'b1, sdio: 1'b0};
      s3_r <= '{sclk: 1'b0, select_n: 1'b1, sdio: 1'b0};
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // Edges of the host clock, only inside a frame
  assign sclk_rise = !s2_r.select_n && s2_r.sclk && !s3_r.sclk;
  assign sclk_fall = !s2_r.select_n && !s2_r.sclk && s3_r.sclk;
  assign byte_in   = {shift_in_r[6:0], s2_r.sdio};  // MSB first

  // Frame sequencer and register file, next values
  always_comb
  begin
    state_nxt      = state_r;
    instr_nxt      = instr_r;
    bit_cnt_nxt    = bit_cnt_r;
    bytes_left_nxt = bytes_left_r;
    addr_nxt       = addr_r;
    shift_in_nxt   = shift_in_r;
    shift_out_nxt  = shift_out_r;
    out_bit_nxt    = out_bit_r;
    drive_nxt      = drive_r;
    wr_nxt         = 1'b0;
    page_nxt       = page_r;
    regs_nxt       = regs_r;
    cfg_nxt        = read_reg(cfg_page_in, cfg_addr_in);
    if (s2_r.select_n)
    begin
      // Frame closed: release the line and forget partial bytes
      state_nxt   = ST_IDLE;
      bit_cnt_nxt = '0;
      drive_nxt   = 1'b0;
    end
    else if (sclk_rise)
    begin
      // Data in is taken on the rising edge
      shift_in_nxt = byte_in;
      bit_cnt_nxt  = bit_cnt_r + 3'h1;
      case (state_r)
        ST_IDLE, ST_INSTR:
        begin
          state_nxt = ST_INSTR;
          if (bit_cnt_r == BYTE_LAST_BIT)
          begin
            instr_nxt      = instr_t'(byte_in);
            addr_nxt       = byte_in[ADDR_W-1:0];
            bytes_left_nxt = {1'b0, byte_in[6:5]} + ONE_BYTE;
            state_nxt      = ST_DATA;
            if (byte_in[7] == RW_READ)
              shift_out_nxt = read_reg(page_idx(page_r), byte_in[ADDR_W-1:0]);
          end
        end
        ST_DATA:
        begin
          if (bit_cnt_r == BYTE_LAST_BIT)
          begin
            if (instr_r.rw == RW_WRITE)
            begin
              wr_nxt = 1'b1;
              if (addr_r == PAGE_REG_ADDR)
              begin
                // Unknown page numbers are dropped so the page stays valid
                if (byte_in == PAGE_CODE_0 || byte_in == PAGE_CODE_1 ||
                    byte_in == PAGE_CODE_TEN)
                  page_nxt = byte_in;
              end
              else
                regs_nxt[page_idx(page_r)][addr_r] = byte_in;
            end
            addr_nxt       = addr_r - 5'h01;
            bytes_left_nxt = bytes_left_r - ONE_BYTE;
            if (bytes_left_r == ONE_BYTE)
              state_nxt = ST_DONE;
            else if (instr_r.rw == RW_READ)
              shift_out_nxt = read_reg(page_idx(page_r), addr_r - 5'h01);
          end
        end
        default:
        begin
          // Bytes past the count are ignored
          state_nxt = ST_DONE;
        end
      endcase
    end
    else if (sclk_fall && state_r == ST_DATA && instr_r.rw == RW_READ)
    begin
      // Read data changes on the falling edge, MSB first
      out_bit_nxt   = shift_out_r[7];
      shift_out_nxt = {shift_out_r[6:0], 1'b0};
      drive_nxt     = 1'b1;
    end
  end

  // Frame sequencer and register file
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_r      <= ST_IDLE;
      instr_r      <= '0;
      bit_cnt_r    <= '0;
      bytes_left_r <= '0;
      addr_r       <= '0;
      shift_in_r   <= '0;
      shift_out_r  <= '0;
      out_bit_r    <= 1'b0;
      drive_r      <= 1'b0;
      wr_r         <= 1'b0;
      page_r       <= PAGE_CODE_0;
      cfg_r        <= REG_RESET;
      for (int p = 0; p < NUM_PAGES; p++)
        for (int a = 0; a < REGS_PER_PAGE - 1; a++)
          regs_r[p][a] <= REG_RESET;
    end
    else
    begin
      state_r      <= state_nxt;
      instr_r      <= instr_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      bytes_left_r <= bytes_left_nxt;
      addr_r       <= addr_nxt;
      shift_in_r   <= shift_in_nxt;
      shift_out_r  <= shift_out_nxt;
      out_bit_r    <= out_bit_nxt;
      drive_r      <= drive_nxt;
      wr_r         <= wr_nxt;
      page_r       <= page_nxt;
      cfg_r        <= cfg_nxt;
      regs_r       <= regs_nxt;
    end
  end

  // Pin steering: one data pin per arrangement, enables active low
  assign sdio_out             = out_bit_r;
  assign sdio_oe_n_out        = !(drive_r && !four_wire_in);
  assign serial_data_out      = out_bit_r;
  assign serial_data_oe_n_out = !(drive_r && four_wire_in);
  assign page_out             = page_r;
  assign cfg_data_out         = cfg_r;
  assign wr_strobe_out        = wr_r;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  AST_SHARED_PIN_ONLY: assert property (!four_wire_in |-> serial_data_oe_n_out)
    else $error("Separate pin driven in 3-wire mode");
  AST_SEPARATE_PIN_ONLY: assert property (four_wire_in |-> sdio_oe_n_out)
    else $error("Shared pin driven in 4-wire mode");
  AST_RELEASE_ON_SELECT: assert property (s2_r.select_n
      |=> sdio_oe_n_out && serial_data_oe_n_out)
    else $error("Line still driven after select rose");
  AST_WRITE_NEVER_DRIVES: assert property (state_r == ST_DATA
      && instr_r.rw == RW_WRITE |-> !drive_r)
    else $error("Read data driven during a write");
  AST_COUNT_DECODE: assert property (sclk_rise && state_r == ST_INSTR
      && bit_cnt_r == BYTE_LAST_BIT |=> bytes_left_r == {1'b0, $past(byte_in[6:5])} + ONE_BYTE
      && addr_r == $past(byte_in[ADDR_W-1:0]))
    else $error("Byte count or first address decoded wrong");
  AST_ADDR_DESCENDS: assert property (sclk_rise && state_r == ST_DATA
      && bit_cnt_r == BYTE_LAST_BIT |=> addr_r == $past(addr_r) - 5'h01)
    else $error("Address did not step down after a data byte");
  AST_PAGE_VALID: assert property (page_r == PAGE_CODE_0 || page_r == PAGE_CODE_1 ||
      page_r == PAGE_CODE_TEN)
    else $error("Active page holds an invalid number");
  AST_PAGE_SWITCH: assert property (wr_nxt && addr_r == PAGE_REG_ADDR
      && byte_in == PAGE_CODE_TEN |=> page_out == PAGE_CODE_TEN)
    else $error("Page register write did not switch page");
  AST_BURST_LIMIT: assert property (state_r == ST_DATA |-> bytes_left_r >= ONE_BYTE &&
      bytes_left_r <= 3'h4)
    else $error("Data byte count outside one to four");
  AST_WRITE_STORES: assert property (wr_r && $past(addr_r) != PAGE_REG_ADDR
      |-> regs_r[page_idx(page_r)][$past(addr_r)] == $past(byte_in))
    else $error("Written byte not stored");

  COV_WRITE_BURST: cover property (wr_r ##[1:400] wr_r);
  COV_READ_DRIVE: cover property (drive_r && !four_wire_in);
  COV_READ_4WIRE: cover property (drive_r && four_wire_in);
  COV_PAGE_TEN: cover property (page_r == PAGE_CODE_TEN);

endmodule

`default_nettype wire

// [test/serial_host_model.sv]
/*
  Host side of the serial port: makes the serial clock, select and write bits,
  and samples read bits. Assumes one caller of xfer at a time; the shared wire
  is resolved here from both ends' enables.
*/
`default_nettype none

module serial_host_model
  import paged_serial_pkg::*;
(
  input  wire logic clk_in,            // System clock, drives the idle pattern, separate-pin memory and contention count
  input  wire logic four_wire_in,      // Arrangement in use
  input  wire logic dev_sdio_in,       // Device value on the shared wire
  input  wire logic dev_sdio_oe_n_in,  // Device shared-wire enable, low drives
  input  wire logic dev_sep_in,        // Device separate read pin
  input  wire logic dev_sep_oe_n_in,   // Device separate pin enable, low drives
  output logic      sclk_out,          // Serial clock, still outside frames
  output logic      select_n_out,      // Frame select, active low
  output logic      sdio_line_out,     // Resolved shared wire
  output int        clash_out          // Cycles with both ends on the shared wire
);
  timeunit 1ns;
  timeprecision 100ps;

  logic host_oe  = 1'b0;  // Host drives the shared wire
  logic host_bit = 1'b0;  // Host value on the shared wire
  logic idle_bit = 1'b0;  // Toggles every cycle so a released wire never looks valid
  logic sep_last = 1'b0;  // Last driven value of the separate pin
  logic miso;             // What the host sees as read data

  initial
  begin
    sclk_out = 1'b0;
    select_n_out = 1'b1;
    clash_out = 0;
  end

  // Idle pattern, released-pin memory and contention count
  always @(posedge clk_in)
  begin
    idle_bit <= ~idle_bit;
    if (!dev_sep_oe_n_in)
      sep_last <= dev_sep_in;
    if (host_oe && !dev_sdio_oe_n_in)
      clash_out <= clash_out + 1;
  end

  // Released separate pin shows the inverse of its last value
  assign sdio_line_out = !dev_sdio_oe_n_in ? dev_sdio_in : (host_oe ? host_bit : idle_bit);
  assign miso = four_wire_in ? (dev_sep_oe_n_in ? ~sep_last : dev_sep_in) : sdio_line_out;

  // One frame: instruction, data bytes, then extra clocks that must be ignored
  task automatic xfer(input logic [7:0] instr, input logic [31:0] wdata, input int extra,
                      output logic [31:0] rdata);
    int nbits;
    nbits = 8 * (int'(instr[6:5]) + 2) + extra;
    rdata = 32'h0000_0000;
    select_n_out = 1'b0;
    host_oe = 1'b1;
    #62.5;
    for (int i = 0; i < nbits; i++)
    begin
      // Host lets go of the shared wire for read data in the 3-wire case
      host_oe = !(instr[7] && !four_wire_in && i >= 8);
      host_bit = i < 8 ? instr[7 - i] : (i < 40 ? wdata[39 - i] : 1'b1);
      #62.5 sclk_out = 1'b1;  // 8 MHz, well under the 25 MHz ceiling
      if (i >= 8 && i < 40)
        rdata[39 - i] = miso;
      #62.5 sclk_out = 1'b0;
    end
    #62.5 select_n_out = 1'b1;
    host_oe = 1'b0;
    #200;
  endtask
endmodule

`default_nettype wire

// [test/test_paged_serial_register_port.sv]
/*
  Self-checking bench for the paged serial register port.
  Assumes the host model makes a 125 ns serial clock unrelated to clk_in.
*/
`default_nettype none

module test_paged_serial_register_port
  import paged_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_in       = 1'b0;   // 100 MHz system clock
  logic       resetn_in    = 1'b0;   // Held low for three cycles
  logic       four_wire_in = 1'b0;   // Starts in the 3-wire arrangement
  logic [1:0] cfg_page_in  = 2'h0;   // Local read port page
  logic [4:0] cfg_addr_in  = 5'h00;  // Local read port address
  logic       sclk, sel_n, sdio_line, sdio_out, sdio_oe_n, sep_data, sep_oe_n, wr_strobe;
  logic [7:0] page_out, cfg_data;
  int         clash;
  int         mismatches = 0;
  int         n_compared = 0;
  int         strobes    = 0;        // Write pulses seen
  int         cycles     = 0;        // Hang guard

  always #5 clk_in = ~clk_in;

  paged_serial_register_port dut (.clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk),
    .serial_select_n_in(sel_n), .sdio_in(sdio_line), .four_wire_in(four_wire_in),
    .cfg_page_in(cfg_page_in), .cfg_addr_in(cfg_addr_in), .sdio_out(sdio_out),
    .sdio_oe_n_out(sdio_oe_n), .serial_data_out(sep_data), .serial_data_oe_n_out(sep_oe_n),
    .page_out(page_out), .cfg_data_out(cfg_data), .wr_strobe_out(wr_strobe));

  serial_host_model host (.clk_in(clk_in), .four_wire_in(four_wire_in), .dev_sdio_in(sdio_out),
    .dev_sdio_oe_n_in(sdio_oe_n), .dev_sep_in(sep_data), .dev_sep_oe_n_in(sep_oe_n),
    .sclk_out(sclk), .select_n_out(sel_n), .sdio_line_out(sdio_line), .clash_out(clash));

  // Strobe count and timeout; 60000 cycles is several times the expected run
  always @(posedge clk_in)
  begin
    cycles++;
    if (wr_strobe === 1'b1)
      strobes++;
    if (cycles == 60000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // Local read port, one cycle of latency plus settling
  task automatic rd_cfg(input logic [1:0] pg, input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_in);
    cfg_page_in <= pg;
    cfg_addr_in <= a;
    repeat (2) @(posedge clk_in);
    #1 d = cfg_data;
  endtask

  task automatic t_reset;
    logic [7:0] d;
    chk8(page_out, PAGE_CODE_0, "page after reset");
    chk8({6'h00, sdio_oe_n, sep_oe_n}, 8'h03, "enables idle");
    rd_cfg(PAGE_IDX_0, 5'h05, d);
    chk8(d, REG_RESET, "register after reset");
  endtask

  // Four-byte write plus one byte beyond the count, which must be dropped
  task automatic t_write_burst;
    logic [31:0] r;
    logic [7:0]  d;
    int          s0;
    s0 = strobes;
    host.xfer({RW_WRITE, 2'h3, 5'h05}, 32'hA1B2_C3D4, 8, r);
    chk_n(strobes - s0, 4, "write pulses");
    for (int b = 0; b < 4; b++)
    begin
      rd_cfg(PAGE_IDX_0, 5'(5 - b), d);
      chk8(d, 8'(32'hA1B2_C3D4 >> (24 - 8 * b)), "burst byte");
    end
    rd_cfg(PAGE_IDX_0, 5'h01, d);
    chk8(d, REG_RESET, "byte beyond count");
  endtask

  // Every count code, each followed by a byte that must be ignored
  task automatic t_counts;
    logic [31:0] r;
    logic [7:0]  d;
    int          s0;
    for (int n = 0; n < 4; n++)
    begin
      s0 = strobes;
      host.xfer({RW_WRITE, 2'(n), 5'h14}, {4{8'(8'h50 + n)}}, 8, r);
      chk_n(strobes - s0, n + 1, "count code pulses");
      rd_cfg(PAGE_IDX_0, 5'(20 - n), d);
      chk8(d, 8'(8'h50 + n), "last byte of count");
      rd_cfg(PAGE_IDX_0, 5'(19 - n), d);
      chk8(d, REG_RESET, "below last byte");
    end
  endtask

  // Read back in both arrangements; the released wire must not pass as data
  task automatic t_read;
    logic [31:0] r;
    for (int fw = 0; fw < 2; fw++)
    begin
      @(posedge clk_in);
      four_wire_in <= 1'(fw);
      @(posedge clk_in);
      host.xfer({RW_READ, 2'h3, 5'h05}, 32'h0000_0000, 0, r);
      for (int b = 0; b < 4; b++)
        chk8(r[31 - 8 * b -: 8], 8'(32'hA1B2_C3D4 >> (24 - 8 * b)),
             "read byte");
      chk8({6'h00, sdio_oe_n, sep_oe_n}, 8'h03, "released after frame");
    end
    chk_n(clash, 0, "shared wire contention");
    @(posedge clk_in);
    four_wire_in <= 1'b0;
  endtask

  // Page switching through the last register of each page
  task automatic t_pages;
    logic [7:0]  codes [3] = '{PAGE_CODE_0, PAGE_CODE_1, PAGE_CODE_TEN};
    logic [1:0]  idx   [3] = '{PAGE_IDX_0, PAGE_IDX_1, PAGE_IDX_TEN};
    logic [31:0] r;
    logic [7:0]  d;
    for (int k = 0; k < 3; k++)
    begin
      host.xfer({RW_WRITE, 2'h0, PAGE_REG_ADDR}, {codes[k], 24'h0}, 0, r);
      chk8(page_out, codes[k], "page switch");
      host.xfer({RW_WRITE, 2'h0, 5'h03}, {8'(8'hC0 + k), 24'h0}, 0, r);
      host.xfer({RW_READ, 2'h0, 5'h03}, 32'h0, 0, r);
      chk8(r[31:24], 8'(8'hC0 + k), "paged read");
    end
    for (int k = 0; k < 3; k++)
    begin
      rd_cfg(idx[k], 5'h03, d);
      chk8(d, 8'(8'hC0 + k), "page storage");
    end
    host.xfer({RW_WRITE, 2'h0, PAGE_REG_ADDR}, 32'h0500_0000, 0, r);
    chk8(page_out, PAGE_CODE_TEN, "invalid page ignored");
    host.xfer({RW_READ, 2'h0, PAGE_REG_ADDR}, 32'h0, 0, r);
    chk8(r[31:24], PAGE_CODE_TEN, "page register read");
    // Unmapped local page index: plain registers read as reset, page register as usual
    rd_cfg(2'h3, 5'h03, d);
    chk8(d, REG_RESET, "unmapped page index");
    rd_cfg(2'h3, PAGE_REG_ADDR, d);
    chk8(d, PAGE_CODE_TEN, "page register on local port");
  endtask

  initial
  begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_write_burst();
    t_counts();
    t_read();
    t_pages();
    final_report();
  end
endmodule

`default_nettype wire
